// [include/phy_strap_params.svh]
// constants for strap capture and power-mode control
`ifndef PHY_STRAP_PARAMS_SVH
`define PHY_STRAP_PARAMS_SVH

`define ADDR_BASIC_CTRL   5'h00
`define ADDR_PCS_CFG      5'h17
`define ADDR_LOOP_BYPASS  5'h18
`define ADDR_TEN_STATUS   5'h1b

`define BASIC_SW_PDN_BIT  11
`define BASIC_ISOLATE_BIT 10
`define PCS_REPEATER_BIT  12
`define PCS_REF_DIS_BIT   7
`define LB_CODER_BIT      14
`define LB_SCR_BIT        13
`define LB_ALIGN_BIT      12
`define TEN_SERIAL_BIT    9

`define PCS_REF_DIS_RST   1'b1
`define SW_PDN_RST        1'b0

`define SYS_CLK_HZ        100000000
`define REF_CLK_HZ        25000000
`define REF_HALF_CYCLES   (`SYS_CLK_HZ / `REF_CLK_HZ / 2)

`endif

// [include/phy_strap_pkg.sv]
// types for strap capture and power-mode control
package phy_strap_pkg;

    typedef enum logic [1:0] {
        LVL_LOW  = 2'b00,
        LVL_MID  = 2'b01,
        LVL_HIGH = 2'b10
    } level_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE    = 2'b00,
        PWR_LOW_START = 2'b01,
        PWR_PIN_DOWN  = 2'b10,
        PWR_SW_DOWN   = 2'b11
    } pwr_state_t;

endpackage

// [rtl/tri_level_resolver.sv]
// resolves a three-level strap pin from two window comparators
`timescale 1ns/1ps
module tri_level_resolver (
    input  wire logic                  mclk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  above_low_i,
    input  wire logic                  above_high_i,
    output phy_strap_pkg::level_t      level_o
);
    import phy_strap_pkg::*;

    logic [1:0] meta_q;
    logic [1:0] sync_q;
    level_t     level_q;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
        end else begin
            meta_q <= {above_high_i, above_low_i};
            sync_q <= meta_q;
        end
    end

    // an open pin sits between the two thresholds
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_q <= LVL_MID;
        end else if (sync_q[1]) begin
            level_q <= LVL_HIGH;
        end else if (!sync_q[0]) begin
            level_q <= LVL_LOW;
        end else begin
            level_q <= LVL_MID;
        end
    end

    assign level_o = level_q;

endmodule // tri_level_resolver

// [rtl/phy_strap_power_mode_control.sv]
// strap capture, power modes, carrier sense and reference clock
`timescale 1ns/1ps
`include "phy_strap_params.svh"
module phy_strap_power_mode_control #(
    parameter int PHY_ADDRESS_STRAPS_W = 5
) (
    input  wire logic                    mclk_i,
    input  wire logic                    rstn_i,
    input  wire logic                    reset_pin_i,
    input  wire logic                    low_power_start_strap_n_i,
    input  wire logic                    power_down_pin_i,
    input  wire logic                    mdc_i,
    input  wire logic                    repeater_strap_i,
    input  wire logic                    serial_ten_strap_i,
    input  wire logic                    coder_bypass_strap_i,
    input  wire logic                    align_bypass_strap_i,
    input  wire logic                    scrambler_bypass_strap_i,
    input  wire logic                    isolate_default_strap_i,
    input  wire logic [PHY_ADDRESS_STRAPS_W-1:0]      phy_address_straps_i,
    input  wire logic                    clkmode_above_low_i,
    input  wire logic                    clkmode_above_high_i,
    input  wire logic [1:0]              autoneg_above_low_i,
    input  wire logic [1:0]              autoneg_above_high_i,
    input  wire logic                    basic_wr_i,
    input  wire logic [15:0]             basic_wdata_i,
    input  wire logic                    pcs_wr_i,
    input  wire logic [15:0]             pcs_wdata_i,
    input  wire logic                    loop_wr_i,
    input  wire logic [15:0]             loop_wdata_i,
    input  wire logic                    ten_wr_i,
    input  wire logic [15:0]             ten_wdata_i,
    input  wire logic                    an_done_i,
    input  wire logic                    an_speed100_i,
    input  wire logic                    an_full_duplex_i,
    input  wire logic                    rx_active_i,
    input  wire logic                    tx_active_i,
    output logic                         crs_o,
    output logic                         speed_ten_indicator_o,
    output logic                         speed_hundred_indicator_o,
    output logic                         full_duplex_o,
    output logic                         reference_clock_output_o,
    output logic                         tx_clk_is_output_o,
    output logic                         mii_isolate_o,
    output logic                         repeater_mode_o,
    output logic                         coder_bypass_o,
    output logic                         scrambler_bypass_o,
    output logic                         align_bypass_o,
    output logic                         serial_ten_o,
    output logic [PHY_ADDRESS_STRAPS_W-1:0]           phy_address_o,
    output logic                         autoneg_enable_o,
    output logic [3:0]                   autoneg_advertise_o,
    output logic                         core_enable_o,
    output phy_strap_pkg::pwr_state_t    power_state_o
);
    import phy_strap_pkg::*;

    localparam int NSYNC = 10 + PHY_ADDRESS_STRAPS_W;
    localparam logic [NSYNC-1:0] PIN_RST = {1'b1, {(NSYNC-1){1'b0}}};
    localparam logic [1:0] REF_LAST = 2'(`REF_HALF_CYCLES - 1);

    logic [NSYNC-1:0]   pin_raw;
    logic [NSYNC-1:0]   pin_meta_q;
    logic [NSYNC-1:0]   pin_sync_q;
    logic               rst_act;
    logic               lps_n_s;
    logic               pd_s;
    logic               mdc_s;
    logic               rst_last_q;
    logic               mdc_last_q;
    logic               rst_release;
    logic               mdc_toggle;
    level_t             lvl [3];
    logic [2:0]         tri_lo;
    logic [2:0]         tri_hi;
    level_t             clkmode_q;
    level_t             an1_q;
    level_t             an0_q;
    logic               lps_strap_q;
    logic               lps_q;
    logic               sw_pdn_q;
    logic               ref_dis_q;
    logic               force_fast_q;
    logic               force_fdx_q;
    pwr_state_t         pwr_d;
    pwr_state_t         pwr_q;
    logic               fast_sel;
    logic               slow_sel;
    logic               fdx;
    logic               ref_run;
    logic [1:0]         ref_cnt_q;

    // every pin passes two flops before any logic reads it
    assign pin_raw = {reset_pin_i, low_power_start_strap_n_i,
                      power_down_pin_i, mdc_i, repeater_strap_i,
                      serial_ten_strap_i, coder_bypass_strap_i,
                      align_bypass_strap_i, scrambler_bypass_strap_i,
                      isolate_default_strap_i, phy_address_straps_i};

    // power-up counts as reset, so the reset flop starts high
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_meta_q <= PIN_RST;
            pin_sync_q <= PIN_RST;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    assign rst_act = pin_sync_q[NSYNC-1];
    assign lps_n_s = pin_sync_q[NSYNC-2];
    assign pd_s    = pin_sync_q[NSYNC-3];
    assign mdc_s   = pin_sync_q[NSYNC-4];

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_last_q <= 1'b1;
            mdc_last_q <= 1'b0;
        end else begin
            rst_last_q <= rst_act;
            mdc_last_q <= mdc_s;
        end
    end

    assign rst_release = rst_last_q & ~rst_act;
    assign mdc_toggle  = mdc_s ^ mdc_last_q;

    assign tri_lo = {clkmode_above_low_i, autoneg_above_low_i};
    assign tri_hi = {clkmode_above_high_i, autoneg_above_high_i};

    // index 2 is the clock-mode strap, 1 and 0 the autoneg straps
    for (genvar g = 0; g < 3; g++) begin : g_tri
        tri_level_resolver u_res (
            .mclk_i       (mclk_i),
            .rstn_i       (rstn_i),
            .above_low_i  (tri_lo[g]),
            .above_high_i (tri_hi[g]),
            .level_o      (lvl[g])
        );
    end

    // straps follow the pins while reset is held, then freeze
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clkmode_q   <= LVL_MID;
            an1_q       <= LVL_MID;
            an0_q       <= LVL_MID;
            lps_strap_q <= 1'b0;
            phy_address_o <= '0;
        end else if (rst_act) begin
            clkmode_q   <= lvl[2];
            an1_q       <= lvl[1];
            an0_q       <= lvl[0];
            lps_strap_q <= ~lps_n_s;
            phy_address_o <= pin_sync_q[PHY_ADDRESS_STRAPS_W-1:0];
        end
    end

    // software writes change the latched bits outside reset only
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            repeater_mode_o    <= 1'b0;
            serial_ten_o       <= 1'b0;
            coder_bypass_o     <= 1'b0;
            align_bypass_o     <= 1'b0;
            scrambler_bypass_o <= 1'b0;
            mii_isolate_o      <= 1'b0;
            sw_pdn_q           <= `SW_PDN_RST;
            ref_dis_q          <= `PCS_REF_DIS_RST;
        end else if (rst_act) begin
            repeater_mode_o    <= pin_sync_q[PHY_ADDRESS_STRAPS_W+5];
            serial_ten_o       <= pin_sync_q[PHY_ADDRESS_STRAPS_W+4];
            coder_bypass_o     <= pin_sync_q[PHY_ADDRESS_STRAPS_W+3];
            align_bypass_o     <= pin_sync_q[PHY_ADDRESS_STRAPS_W+2];
            scrambler_bypass_o <= pin_sync_q[PHY_ADDRESS_STRAPS_W+1];
            mii_isolate_o      <= pin_sync_q[PHY_ADDRESS_STRAPS_W];
            sw_pdn_q           <= `SW_PDN_RST;
            ref_dis_q          <= `PCS_REF_DIS_RST;
        end else begin
            if (basic_wr_i) begin
                sw_pdn_q      <= basic_wdata_i[`BASIC_SW_PDN_BIT];
                mii_isolate_o <= basic_wdata_i[`BASIC_ISOLATE_BIT];
            end
            if (pcs_wr_i) begin
                repeater_mode_o <= pcs_wdata_i[`PCS_REPEATER_BIT];
                ref_dis_q       <= pcs_wdata_i[`PCS_REF_DIS_BIT];
            end
            if (loop_wr_i) begin
                coder_bypass_o     <= loop_wdata_i[`LB_CODER_BIT];
                scrambler_bypass_o <= loop_wdata_i[`LB_SCR_BIT];
                align_bypass_o     <= loop_wdata_i[`LB_ALIGN_BIT];
            end
            if (ten_wr_i) begin
                serial_ten_o <= ten_wdata_i[`TEN_SERIAL_BIT];
            end
        end
    end

    // tri-level autoneg decode: mid on one side forces the mode
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            autoneg_enable_o    <= 1'b1;
            autoneg_advertise_o <= 4'hf;
            force_fast_q        <= 1'b0;
            force_fdx_q         <= 1'b0;
        end else if (an1_q == LVL_MID && an0_q == LVL_MID) begin
            autoneg_enable_o    <= 1'b1;
            autoneg_advertise_o <= 4'hf;
            force_fast_q        <= 1'b0;
            force_fdx_q         <= 1'b0;
        end else if (an1_q == LVL_MID || an0_q == LVL_MID) begin
            autoneg_enable_o    <= 1'b0;
            autoneg_advertise_o <= 4'h0;
            force_fast_q        <= (an1_q == LVL_MID);
            force_fdx_q         <= (an1_q == LVL_MID) ?
                                   (an0_q == LVL_HIGH) : (an1_q == LVL_HIGH);
        end else begin
            // advertise bits: 100 full, 100 half, 10 full, 10 half
            autoneg_enable_o    <= 1'b1;
            autoneg_advertise_o <= 4'h1 << {an1_q == LVL_HIGH,
                                            an0_q == LVL_HIGH};
            force_fast_q        <= (an1_q == LVL_HIGH);
            force_fdx_q         <= (an0_q == LVL_HIGH);
        end
    end

    // set on release wins over a same-cycle MDC toggle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lps_q <= 1'b0;
        end else if (rst_release && lps_strap_q) begin
            lps_q <= 1'b1;
        end else if (rst_act || mdc_toggle) begin
            lps_q <= 1'b0;
        end
    end

    // the pin mode draws least, so it takes priority
    always_comb begin
        if (pd_s) begin
            pwr_d = PWR_PIN_DOWN;
        end else if (lps_q) begin
            pwr_d = PWR_LOW_START;
        end else if (sw_pdn_q) begin
            pwr_d = PWR_SW_DOWN;
        end else begin
            pwr_d = PWR_ACTIVE;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_q         <= PWR_ACTIVE;
            core_enable_o <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            case (pwr_q)
                PWR_ACTIVE: core_enable_o <= ~rst_act;
                default:    core_enable_o <= 1'b0;
            endcase
        end
    end

    assign power_state_o = pwr_q;

    assign fast_sel = autoneg_enable_o ? (an_done_i & an_speed100_i)
                                       : force_fast_q;
    assign slow_sel = autoneg_enable_o ? (an_done_i & ~an_speed100_i)
                                       : ~force_fast_q;
    assign fdx    = autoneg_enable_o ? (an_done_i & an_full_duplex_i)
                                     : force_fdx_q;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            speed_ten_indicator_o     <= 1'b0;
            speed_hundred_indicator_o <= 1'b0;
            full_duplex_o             <= 1'b0;
            crs_o                     <= 1'b0;
        end else begin
            speed_ten_indicator_o     <= slow_sel;
            speed_hundred_indicator_o <= fast_sel;
            full_duplex_o             <= fdx;
            if (pwr_q != PWR_ACTIVE) begin
                crs_o <= 1'b0;
            end else if (repeater_mode_o || full_duplex_o) begin
                crs_o <= rx_active_i;
            end else begin
                crs_o <= rx_active_i | tx_active_i;
            end
        end
    end

    // reference output is stopped with the rest of the core
    assign ref_run = (pwr_q == PWR_ACTIVE) && !rst_act &&
                     ((clkmode_q == LVL_HIGH) || !ref_dis_q);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_cnt_q                <= 2'h0;
            reference_clock_output_o <= 1'b0;
            tx_clk_is_output_o       <= 1'b0;
        end else begin
            tx_clk_is_output_o <= (clkmode_q == LVL_LOW);
            if (!ref_run) begin
                ref_cnt_q                <= 2'h0;
                reference_clock_output_o <= 1'b0;
            end else if (ref_cnt_q == REF_LAST) begin
                ref_cnt_q                <= 2'h0;
                reference_clock_output_o <= ~reference_clock_output_o;
            end else begin
                ref_cnt_q <= ref_cnt_q + 2'h1;
            end
        end
    end

    property p_low_start_entry;
        @(posedge mclk_i) disable iff (!rstn_i)
        rst_release && lps_strap_q && !pd_s |-> ##2 pwr_q == PWR_LOW_START;
    endproperty
    a_low_start_entry: assert property (p_low_start_entry)
        else $error("low-power start not entered");

    property p_low_start_exit;
        @(posedge mclk_i) disable iff (!rstn_i)
        lps_q && !rst_release && (mdc_toggle || rst_act) |=> !lps_q;
    endproperty
    a_low_start_exit: assert property (p_low_start_exit)
        else $error("low-power start did not end");

    property p_pin_down;
        @(posedge mclk_i) disable iff (!rstn_i)
        pd_s |=> pwr_q == PWR_PIN_DOWN ##1 !core_enable_o;
    endproperty
    a_pin_down: assert property (p_pin_down)
        else $error("power-down pin ignored");

    property p_sw_down;
        @(posedge mclk_i) disable iff (!rstn_i)
        sw_pdn_q && !pd_s && !lps_q |=> pwr_q == PWR_SW_DOWN;
    endproperty
    a_sw_down: assert property (p_sw_down)
        else $error("software power-down ignored");

    property p_crs_rx_only;
        @(posedge mclk_i) disable iff (!rstn_i)
        pwr_q == PWR_ACTIVE && (repeater_mode_o || full_duplex_o)
        |=> crs_o == $past(rx_active_i);
    endproperty
    a_crs_rx_only: assert property (p_crs_rx_only)
        else $error("carrier sense not receive only");

    property p_crs_half;
        @(posedge mclk_i) disable iff (!rstn_i)
        pwr_q == PWR_ACTIVE && !repeater_mode_o && !full_duplex_o
        |=> crs_o == ($past(rx_active_i) || $past(tx_active_i));
    endproperty
    a_crs_half: assert property (p_crs_half)
        else $error("carrier sense misses transmit");

    property p_forced_speed;
        @(posedge mclk_i) disable iff (!rstn_i)
        !autoneg_enable_o |=> speed_hundred_indicator_o ==
        $past(force_fast_q) && speed_ten_indicator_o !=
        speed_hundred_indicator_o;
    endproperty
    a_forced_speed: assert property (p_forced_speed)
        else $error("speed indicator wrong");

    property p_strap_latch;
        @(posedge mclk_i) disable iff (!rstn_i)
        $fell(rst_act) |-> repeater_mode_o == $past(pin_sync_q[PHY_ADDRESS_STRAPS_W+5])
        && mii_isolate_o == $past(pin_sync_q[PHY_ADDRESS_STRAPS_W])
        && coder_bypass_o == $past(pin_sync_q[PHY_ADDRESS_STRAPS_W+3]);
    endproperty
    a_strap_latch: assert property (p_strap_latch)
        else $error("strap not latched at reset release");

    property p_tx_clk_dir;
        @(posedge mclk_i) disable iff (!rstn_i)
        !rst_act && !rst_last_q
        |-> tx_clk_is_output_o == (clkmode_q == LVL_LOW);
    endproperty
    a_tx_clk_dir: assert property (p_tx_clk_dir)
        else $error("transmit clock direction wrong");

    property p_ref_idle;
        @(posedge mclk_i) disable iff (!rstn_i)
        !ref_run [*2] |-> !reference_clock_output_o;
    endproperty
    a_ref_idle: assert property (p_ref_idle)
        else $error("reference output runs while disabled");

    property p_adv_all;
        @(posedge mclk_i) disable iff (!rstn_i)
        an1_q == LVL_MID && an0_q == LVL_MID
        |=> autoneg_enable_o && autoneg_advertise_o == 4'hf;
    endproperty
    a_adv_all: assert property (p_adv_all)
        else $error("advertise-all not selected");

    c_low_start: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        pwr_q == PWR_LOW_START ##1 mdc_toggle);
    c_sw_down: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        pwr_q == PWR_SW_DOWN);
    c_ref_clk: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(reference_clock_output_o));
    c_crs_tx: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        crs_o && !rx_active_i && !repeater_mode_o);

endmodule // phy_strap_power_mode_control

// [test/strap_board_model.sv]
// board side model: strap dividers, comparators, management clock
`timescale 1ns/1ps
module strap_board_model (
    input  wire logic                  mclk_i,
    input  wire logic                  rstn_i,
    input  wire phy_strap_pkg::level_t clkmode_lvl_i,
    input  wire phy_strap_pkg::level_t an1_lvl_i,
    input  wire phy_strap_pkg::level_t an0_lvl_i,
    input  wire logic                  mdc_toggle_i,
    output logic                       clkmode_above_low_o,
    output logic                       clkmode_above_high_o,
    output logic [1:0]                 an_above_low_o,
    output logic [1:0]                 an_above_high_o,
    output logic                       mdc_o
);
    import phy_strap_pkg::*;
    // mid level sits between both thresholds, like a floating pin
    assign clkmode_above_low_o  = clkmode_lvl_i != LVL_LOW;
    assign clkmode_above_high_o = clkmode_lvl_i == LVL_HIGH;
    assign an_above_low_o   = {an1_lvl_i != LVL_LOW, an0_lvl_i != LVL_LOW};
    assign an_above_high_o  = {an1_lvl_i == LVL_HIGH, an0_lvl_i == LVL_HIGH};
    // management clock stands still unless a toggle is asked for
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i)
            mdc_o <= 1'b0;
        else if (mdc_toggle_i)
            mdc_o <= ~mdc_o;
    end
endmodule // strap_board_model

// [test/tb_phy_strap_power_mode_control.sv]
// self-checking bench for strap capture and power-mode control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_phy_strap_power_mode_control;
    import phy_strap_pkg::*;
    logic mclk_i = 0, rstn_i = 0, reset_pin_i = 1, mdc_i, mdc_toggle = 0;
    logic low_power_start_strap_n_i = 1, power_down_pin_i = 0;
    logic repeater_strap_i = 0, serial_ten_strap_i = 0;
    logic coder_bypass_strap_i = 0, align_bypass_strap_i = 0;
    logic scrambler_bypass_strap_i = 0, isolate_default_strap_i = 0;
    logic [4:0] phy_address_straps_i = 5'h00, phy_address_o;
    logic clkmode_above_low_i, clkmode_above_high_i;
    logic [1:0] autoneg_above_low_i, autoneg_above_high_i;
    logic basic_wr_i = 0, pcs_wr_i = 0, loop_wr_i = 0, ten_wr_i = 0;
    logic [15:0] basic_wdata_i = 16'h0000, pcs_wdata_i = 16'h0000;
    logic [15:0] loop_wdata_i = 16'h0000, ten_wdata_i = 16'h0000;
    logic an_done_i = 0, an_speed100_i = 0, an_full_duplex_i = 0;
    logic rx_active_i = 0, tx_active_i = 0;
    logic crs_o, speed_ten_indicator_o, speed_hundred_indicator_o;
    logic full_duplex_o, reference_clock_output_o, tx_clk_is_output_o;
    logic mii_isolate_o, repeater_mode_o, coder_bypass_o;
    logic scrambler_bypass_o, align_bypass_o, serial_ten_o;
    logic autoneg_enable_o, core_enable_o;
    logic [3:0] autoneg_advertise_o;
    pwr_state_t power_state_o;
    level_t clkmode_lvl = LVL_MID, an1_lvl = LVL_MID, an0_lvl = LVL_MID;
    int n_errors = 0, checked = 0, cycles = 0;

    phy_strap_power_mode_control #(.PHY_ADDRESS_STRAPS_W(5)) dut (.*);
    strap_board_model board (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .clkmode_lvl_i(clkmode_lvl),
        .an1_lvl_i(an1_lvl), .an0_lvl_i(an0_lvl), .mdc_toggle_i(mdc_toggle),
        .clkmode_above_low_o(clkmode_above_low_i),
        .clkmode_above_high_o(clkmode_above_high_i),
        .an_above_low_o(autoneg_above_low_i),
        .an_above_high_o(autoneg_above_high_i), .mdc_o(mdc_i));

    always #5 mclk_i = ~mclk_i;
    // run is a few hundred cycles; the ceiling leaves ample margin
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // pin held long enough for the three-level decode to settle
    task automatic strap_reset(input level_t t, input level_t a1,
                               input level_t a0);
        clkmode_lvl = t;
        an1_lvl = a1;
        an0_lvl = a0;
        reset_pin_i = 1;
        cyc(8);
        reset_pin_i = 0;
        cyc(8);
    endtask
    task automatic wr_basic(input logic [15:0] d);
        basic_wdata_i = d;
        basic_wr_i = 1;
        cyc(1);
        basic_wr_i = 0;
        cyc(4);
    endtask
    task automatic count_ref(output int n);
        logic p;
        n = 0;
        p = reference_clock_output_o;
        repeat (16) begin
            cyc(1);
            if (reference_clock_output_o !== p)
                n++;
            p = reference_clock_output_o;
        end
    endtask

    task automatic t_straps();
        int n;
        {repeater_strap_i, serial_ten_strap_i, coder_bypass_strap_i} = 3'h7;
        {align_bypass_strap_i, scrambler_bypass_strap_i} = 2'h1;
        isolate_default_strap_i = 1;
        phy_address_straps_i = 5'h15;
        strap_reset(LVL_HIGH, LVL_MID, LVL_HIGH);
        `CHK("rep", 1'b1, repeater_mode_o)
        `CHK("ser", 1'b1, serial_ten_o)
        `CHK("byp", 3'h6, {coder_bypass_o, scrambler_bypass_o, align_bypass_o})
        `CHK("iso", 1'b1, mii_isolate_o)
        `CHK("adr", 5'h15, phy_address_o)
        `CHK("spd", 2'h2, {speed_hundred_indicator_o, speed_ten_indicator_o})
        `CHK("fdx", 2'h2, {full_duplex_o, autoneg_enable_o})
        `CHK("txo", 1'b0, tx_clk_is_output_o)
        count_ref(n);
        `CHK("ref", 8, n)
        {repeater_strap_i, serial_ten_strap_i, isolate_default_strap_i} = 3'h0;
        cyc(4);
        `CHK("hold", 3'h7, {repeater_mode_o, serial_ten_o, mii_isolate_o})
    endtask
    task automatic t_tcm();
        int n;
        strap_reset(LVL_LOW, LVL_MID, LVL_LOW);
        `CHK("txo", 1'b1, tx_clk_is_output_o)
        count_ref(n);
        `CHK("ref", 0, n)
        strap_reset(LVL_MID, LVL_MID, LVL_LOW);
        `CHK("txo", 1'b0, tx_clk_is_output_o)
        count_ref(n);
        `CHK("ref", 0, n)
        pcs_wr_i = 1;
        cyc(1);
        pcs_wr_i = 0;
        cyc(4);
        count_ref(n);
        `CHK("ref", 8, n)
    endtask
    task automatic t_lps();
        low_power_start_strap_n_i = 0;
        strap_reset(LVL_MID, LVL_MID, LVL_MID);
        low_power_start_strap_n_i = 1;
        `CHK("pwr", PWR_LOW_START, power_state_o)
        `CHK("core", 1'b0, core_enable_o)
        cyc(8);
        `CHK("pwr", PWR_LOW_START, power_state_o)
        mdc_toggle = 1;
        cyc(1);
        mdc_toggle = 0;
        cyc(8);
        `CHK("pwr", PWR_ACTIVE, power_state_o)
        `CHK("core", 1'b1, core_enable_o)
        `CHK("adv", 5'h1f, {autoneg_enable_o, autoneg_advertise_o})
    endtask
    task automatic t_pdn();
        power_down_pin_i = 1;
        cyc(6);
        `CHK("pwr", PWR_PIN_DOWN, power_state_o)
        `CHK("core", 1'b0, core_enable_o)
        // pin-driven mode must win over a software request
        wr_basic(16'h0800);
        `CHK("pwr", PWR_PIN_DOWN, power_state_o)
        power_down_pin_i = 0;
        cyc(6);
        `CHK("pwr", PWR_SW_DOWN, power_state_o)
        `CHK("core", 1'b0, core_enable_o)
        wr_basic(16'h0000);
        `CHK("pwr", PWR_ACTIVE, power_state_o)
    endtask
    task automatic t_crs();
        strap_reset(LVL_MID, LVL_LOW, LVL_MID);
        `CHK("spd", 2'h1, {speed_hundred_indicator_o, speed_ten_indicator_o})
        tx_active_i = 1;
        cyc(2);
        `CHK("crs", 1'b1, crs_o)
        repeater_strap_i = 1;
        strap_reset(LVL_MID, LVL_LOW, LVL_MID);
        `CHK("crs", 1'b0, crs_o)
        repeater_strap_i = 0;
        strap_reset(LVL_MID, LVL_HIGH, LVL_MID);
        `CHK("crs", 1'b0, crs_o)
        rx_active_i = 1;
        cyc(2);
        `CHK("crs", 1'b1, crs_o)
        {rx_active_i, tx_active_i} = 2'h0;
    endtask
    task automatic t_an();
        strap_reset(LVL_MID, LVL_HIGH, LVL_HIGH);
        `CHK("adv", 5'h18, {autoneg_enable_o, autoneg_advertise_o})
        `CHK("spd", 2'h0, {speed_hundred_indicator_o, speed_ten_indicator_o})
        {an_done_i, an_speed100_i, an_full_duplex_i} = 3'h7;
        cyc(2);
        `CHK("spd", 2'h2, {speed_hundred_indicator_o, speed_ten_indicator_o})
        `CHK("afdx", 1'b1, full_duplex_o)
    endtask
    // software overrides of latched bits, several strobes at once
    task automatic t_wr();
        loop_wdata_i = 16'h5000;
        ten_wdata_i = 16'h0200;
        pcs_wdata_i = 16'h1080;
        {loop_wr_i, ten_wr_i, pcs_wr_i} = 3'h7;
        cyc(1);
        {loop_wr_i, ten_wr_i, pcs_wr_i} = 3'h0;
        wr_basic(16'h0400);
        `CHK("wcod", 1'b1, coder_bypass_o)
        `CHK("wscr", 1'b0, scrambler_bypass_o)
        `CHK("walg", 1'b1, align_bypass_o)
        `CHK("wser", 1'b1, serial_ten_o)
        `CHK("wrep", 1'b1, repeater_mode_o)
        `CHK("wiso", 1'b1, mii_isolate_o)
    endtask

    initial begin
        cyc(10);
        rstn_i = 1;
        t_straps();
        t_tcm();
        t_lps();
        t_pdn();
        t_crs();
        t_an();
        t_wr();
        test_done();
    end
endmodule // tb_phy_strap_power_mode_control
